//--- verilog/emp_pkg.sv
// constants and carrier types for the shared event pin selector
// assumes one 200 MHz clock and a simple register port in front of the regs
// Notes on behaviour
// RULE_01: timer, osc-fail, alarm 1 and watchdog requests OR into one request.
// RULE_02: frequency test, when selected, drives a 512 Hz square on the pin.
// RULE_03: pin is open drain; only pulled low, external pull-up gives high.
// RULE_04: on battery only alarm 1 and osc-fail count; on main all four.
// RULE_05: main supply, level 0 and test 0: pin low always.
// RULE_06: main supply, test 1: square when level 0 or nothing enabled.
// RULE_07: main supply, level 1 and some enable: pin low while source asserted.
// RULE_08: main supply, level 1, test 0, nothing enabled: pin high.
// RULE_09: level bit 7, test enable bit 6 of calibration register 08h.
// RULE_10: alarm 1 enable bit 7, backup enable bit 5 of register 0Ah.
// RULE_11: osc-fail enable bit 7 of 09h; timer enable bit 5 of 11h.
// RULE_12: on battery the frequency test is off and its bit ignored.
// RULE_13: on battery with backup enable 0 the pin stays high.
// RULE_14: on battery, level 1 and no alarm or osc-fail enable: pin high.
// RULE_15: on battery, backup enable 1 and level 0: pin low.
// RULE_16: host sets level, backup enable and a source enable for battery interrupts.
// RULE_17: host reads flags at 0Fh to see which sources hold the pin.
// RULE_18: further flags while pin is low cause no extra pin transition.
// RULE_19: host services every asserting source before the pin releases.
// RULE_20: cold power-up sets level and square enable, clears rest; warm clears test, watchdog. Cold start also loads 03h at 11h and sets osc-fail flag.
// RULE_21: osc-fail flag clears only by writing it 0; flag reads harmless.
// RULE_22: clearing osc-fail enable drops request; re-setting with flag 1 reasserts.
// RULE_23: pin choice is logic over control bits, supply state and flags.
package emp_pkg;
  localparam logic [7:0] ADDR_CAL = 8'h08;
  localparam logic [7:0] ADDR_WDOG = 8'h09;
  localparam logic [7:0] ADDR_A1MON = 8'h0A;
  localparam logic [7:0] ADDR_FLAGS = 8'h0F;
  localparam logic [7:0] ADDR_TCTL = 8'h11;
  // field positions
  localparam int BIT_OUT = 7;
  localparam int BIT_FT = 6;
  localparam int BIT_OSC_FAIL_IRQ_ENABLE = 7;
  localparam int BIT_ALARM1_IRQ_ENABLE = 7;
  localparam int BIT_SQUARE_WAVE_ENABLE = 6;
  localparam int BIT_ABE = 5;
  localparam int BIT_TIE = 5;
  localparam logic [7:0] WDOG_CNT_MASK = 8'h7F;
  // flag register layout
  localparam int FBIT_WDF = 7;
  localparam int FBIT_AF = 6;
  localparam int FBIT_TF = 3;
  localparam int FBIT_OF = 2;
  // cold power-up values
  localparam logic [7:0] CAL_COLD = 8'h80;
  localparam logic [7:0] WDOG_COLD = 8'h00;
  localparam logic [7:0] A1MON_COLD = 8'h40;
  localparam logic [7:0] TCTL_COLD = 8'h03;
  localparam logic OF_COLD = 1'b1;
  // frequency test timing
  localparam int CLK_HZ = 200_000_000;
  localparam int FT_HZ = 512;
  localparam int FT_HALF_CYCLES = CLK_HZ / (2 * FT_HZ);
  localparam int FT_CNT_W = 18;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } emp_reg_req_t;

  typedef struct packed {
    logic timer_evt;
    logic alarm1_evt;
    logic wdog_evt;
    logic osc_fail_evt;
  } emp_src_t;

  typedef struct packed {
    logic wdf;
    logic af;
    logic tf;
    logic of;
  } emp_flags_t;
endpackage

//--- verilog/emp_ft_divider.sv
// frequency test square generator
// assumes enable is a level from the owning block
`timescale 1ns/1ps
`default_nettype none
module emp_ft_divider #(
  parameter int HALF_CYCLES = emp_pkg::FT_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  output logic square
);
  import emp_pkg::*;

  typedef struct packed {
    logic [FT_CNT_W-1:0] cnt;
    logic sq;
  } emp_div_state_t;

  localparam logic [FT_CNT_W-1:0] LAST = FT_CNT_W'(HALF_CYCLES - 1);

  emp_div_state_t st_reg;
  emp_div_state_t st_next;

  // held low while disabled so every test burst starts on the same phase
  always_comb begin
    st_next = st_reg;
    if (!enable) begin
      st_next.cnt = '0;
      st_next.sq = 1'b0;
    end else if (st_reg.cnt == LAST) begin
      st_next.cnt = '0;
      st_next.sq = ~st_reg.sq;
    end else begin
      st_next.cnt = st_reg.cnt + FT_CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign square = st_reg.sq;
endmodule
`default_nettype wire

//--- verilog/emp_event_pin_mux.sv
// event pin selector: control registers, source flags and pin priority
// assumes register port and source events are synchronous to CLOCK
`timescale 1ns/1ps
`default_nettype none
module emp_event_pin_mux #(
  parameter int FT_HALF = emp_pkg::FT_HALF_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic COLD_START,
  input wire logic BACKUP_MODE,
  input wire emp_pkg::emp_reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire emp_pkg::emp_src_t SRC_EVT,
  output logic SHARED_EVENT_PIN_O,
  output logic SHARED_EVENT_PIN_OE,
  output logic SQUARE_WAVE_ENABLE,
  output logic FREQ_TEST_ACTIVE
);
  import emp_pkg::*;

  typedef struct packed {
    logic [7:0] cal;
    logic [7:0] wdog;
    logic [7:0] a1mon;
    logic [7:0] tctl;
    emp_flags_t flg;
    logic [7:0] rdata;
    logic pin_low;
    logic ft_act;
  } emp_state_t;

  emp_state_t st_reg;
  emp_state_t st_next;

  logic ft_square;

  // register fields
  logic out_bit;
  logic ft_bit;
  logic osc_fail_irq_enable;
  logic alarm1_irq_enable;
  logic abe;
  logic timer_irq_enable;
  logic wd_running;

  // request terms
  logic req_timer;
  logic req_alarm1;
  logic req_wdog;
  logic req_osc;
  logic irq_main;
  logic irq_backup;
  logic any_en_main;
  logic any_en_backup;

  // bus decode
  logic wr_cal;
  logic wr_wdog;
  logic wr_a1mon;
  logic wr_flags;
  logic wr_tctl;
  logic rd_flags;

  function automatic logic hit(input emp_reg_req_t req, input logic [7:0] addr);
    hit = (req.addr == addr);
  endfunction

  function automatic logic [7:0] flags_image(input emp_flags_t f);
    logic [7:0] v;
    v = 8'h00;
    v[FBIT_WDF] = f.wdf;
    v[FBIT_AF] = f.af;
    v[FBIT_TF] = f.tf;
    v[FBIT_OF] = f.of;
    flags_image = v;
  endfunction

  emp_ft_divider #(
    .HALF_CYCLES(FT_HALF)
  ) u_ft_div (
    .clock(CLOCK),
    .rstn(RSTN),
    .enable(st_reg.ft_act),
    .square(ft_square)
  );

  always_comb begin
    out_bit = st_reg.cal[BIT_OUT]; // [RULE_09]
    ft_bit = st_reg.cal[BIT_FT]; // [RULE_09]
    alarm1_irq_enable = st_reg.a1mon[BIT_ALARM1_IRQ_ENABLE]; // [RULE_10]
    abe = st_reg.a1mon[BIT_ABE]; // [RULE_10]
    osc_fail_irq_enable = st_reg.wdog[BIT_OSC_FAIL_IRQ_ENABLE]; // [RULE_11]
    timer_irq_enable = st_reg.tctl[BIT_TIE]; // [RULE_11]
    // a loaded watchdog count counts as an enabled source
    wd_running = |(st_reg.wdog & WDOG_CNT_MASK);
  end

  always_comb begin
    // enable gating only; a cleared enable drops its request at once
    req_timer = timer_irq_enable & st_reg.flg.tf;
    req_alarm1 = alarm1_irq_enable & st_reg.flg.af;
    req_wdog = wd_running & st_reg.flg.wdf;
    req_osc = osc_fail_irq_enable & st_reg.flg.of; // [RULE_22]
    irq_main = req_timer | req_alarm1 | req_wdog | req_osc; // [RULE_01]
    irq_backup = req_alarm1 | req_osc; // [RULE_04]
    any_en_main = alarm1_irq_enable | osc_fail_irq_enable | timer_irq_enable | wd_running; // [RULE_04]
    any_en_backup = alarm1_irq_enable | osc_fail_irq_enable; // [RULE_04]
  end

  always_comb begin
    wr_cal = REG_REQ.we & hit(REG_REQ, ADDR_CAL);
    wr_wdog = REG_REQ.we & hit(REG_REQ, ADDR_WDOG);
    wr_a1mon = REG_REQ.we & hit(REG_REQ, ADDR_A1MON);
    wr_flags = REG_REQ.we & hit(REG_REQ, ADDR_FLAGS);
    wr_tctl = REG_REQ.we & hit(REG_REQ, ADDR_TCTL);
    rd_flags = REG_REQ.re & hit(REG_REQ, ADDR_FLAGS);
  end

  always_comb begin
    st_next = st_reg;

    // control register writes
    if (wr_cal) begin
      st_next.cal = REG_REQ.wdata;
    end
    if (wr_wdog) begin
      st_next.wdog = REG_REQ.wdata;
    end
    if (wr_a1mon) begin
      st_next.a1mon = REG_REQ.wdata;
    end
    if (wr_tctl) begin
      st_next.tctl = REG_REQ.wdata;
    end

    // flag clears; the sets below are applied after, so an event wins
    if (rd_flags) begin
      st_next.flg.af = 1'b0;
      st_next.flg.tf = 1'b0;
    end
    // the osc-fail flag ignores reads and falls only when written 0
    if (wr_flags && !REG_REQ.wdata[FBIT_OF]) begin
      st_next.flg.of = 1'b0; // [RULE_21]
    end
    // reloading the watchdog is how the host services its flag
    if (wr_wdog) begin
      st_next.flg.wdf = 1'b0; // [RULE_19]
    end

    // flag sets; timer and watchdog are dead on battery
    if (SRC_EVT.timer_evt && !BACKUP_MODE) begin
      st_next.flg.tf = 1'b1; // [RULE_04]
    end
    if (SRC_EVT.wdog_evt && !BACKUP_MODE) begin
      st_next.flg.wdf = 1'b1; // [RULE_04]
    end
    if (SRC_EVT.alarm1_evt) begin
      st_next.flg.af = 1'b1;
    end
    if (SRC_EVT.osc_fail_evt) begin
      st_next.flg.of = 1'b1;
    end

    // read data, unmapped reads as zero
    if (REG_REQ.re) begin
      case (REG_REQ.addr)
        ADDR_CAL: begin
          st_next.rdata = st_reg.cal;
        end
        ADDR_WDOG: begin
          st_next.rdata = st_reg.wdog;
        end
        ADDR_A1MON: begin
          st_next.rdata = st_reg.a1mon;
        end
        ADDR_FLAGS: begin
          st_next.rdata = flags_image(st_reg.flg); // [RULE_17]
        end
        ADDR_TCTL: begin
          st_next.rdata = st_reg.tctl;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // test generator runs only on main supply
    st_next.ft_act = 1'b0;
    if (!BACKUP_MODE && ft_bit) begin
      if (!out_bit || !any_en_main) begin
        st_next.ft_act = 1'b1; // [RULE_06]
      end
    end

    // pin priority; a level, so later flags add no edge while already low
    if (BACKUP_MODE) begin
      // frequency test bit takes no part here
      if (!abe) begin
        st_next.pin_low = 1'b0; // [RULE_12] [RULE_13]
      end else if (!out_bit) begin
        st_next.pin_low = 1'b1; // [RULE_15]
      end else if (!any_en_backup) begin
        st_next.pin_low = 1'b0; // [RULE_14]
      end else begin
        st_next.pin_low = irq_backup; // [RULE_18] [RULE_23]
      end
    end else begin
      if (!out_bit && !ft_bit) begin
        st_next.pin_low = 1'b1; // [RULE_05]
      end else if (ft_bit && (!out_bit || !any_en_main)) begin
        // square phase low pulls the pin
        st_next.pin_low = ~ft_square; // [RULE_02] [RULE_06]
      end else if (out_bit && any_en_main) begin
        st_next.pin_low = irq_main; // [RULE_07] [RULE_18] [RULE_23]
      end else begin
        st_next.pin_low = 1'b0; // [RULE_08]
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      if (COLD_START) begin
        // first application of power: full defaults
        st_reg.cal <= CAL_COLD; // [RULE_20]
        st_reg.wdog <= WDOG_COLD; // [RULE_20]
        st_reg.a1mon <= A1MON_COLD; // [RULE_20]
        st_reg.tctl <= TCTL_COLD;
        st_reg.flg <= '0;
        st_reg.flg.of <= OF_COLD;
      end else begin
        // backed-up power-up keeps everything but test and watchdog
        st_reg.cal[BIT_FT] <= 1'b0; // [RULE_20]
        st_reg.wdog <= st_reg.wdog & ~WDOG_CNT_MASK; // [RULE_20]
      end
      st_reg.rdata <= 8'h00;
      st_reg.pin_low <= 1'b0;
      st_reg.ft_act <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // open drain: the output level is fixed low, only the enable moves
  assign SHARED_EVENT_PIN_O = 1'b0; // [RULE_03]
  assign SHARED_EVENT_PIN_OE = st_reg.pin_low; // [RULE_03]
  assign REG_RDATA = st_reg.rdata;
  assign SQUARE_WAVE_ENABLE = st_reg.a1mon[BIT_SQUARE_WAVE_ENABLE];
  assign FREQ_TEST_ACTIVE = st_reg.ft_act;
endmodule
`default_nettype wire

//--- tb/emp_event_pin_monitor.sv
// port checker for the event pin selector, bound onto its top module
// assumes a cold start comes before any warm one
`timescale 1ns/1ps
`default_nettype none
module emp_event_pin_monitor (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic COLD_START,
  input wire logic BACKUP_MODE,
  input wire emp_pkg::emp_reg_req_t REG_REQ,
  input wire logic SHARED_EVENT_PIN_O,
  input wire logic SHARED_EVENT_PIN_OE,
  input wire logic SQUARE_WAVE_ENABLE,
  input wire logic FREQ_TEST_ACTIVE
);
  import emp_pkg::*;
  logic out_reg, ft_reg, abe_reg;
  // shadows of written control bits; warm start keeps out and abe
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ft_reg <= 1'b0;
      if (COLD_START) begin
        out_reg <= 1'b1;
        abe_reg <= 1'b0;
      end
    end else if (REG_REQ.we && REG_REQ.addr == ADDR_CAL) begin
      out_reg <= REG_REQ.wdata[BIT_OUT];
      ft_reg <= REG_REQ.wdata[BIT_FT];
    end else if (REG_REQ.we && REG_REQ.addr == ADDR_A1MON) begin
      abe_reg <= REG_REQ.wdata[BIT_ABE];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // two samples, so the one-cycle pin latency is covered
  sequence s_held(c);
    c [*2];
  endsequence
  property p_drain; !SHARED_EVENT_PIN_O; endproperty
  property p_rst;
    disable iff (1'b0) !RSTN |=> !SHARED_EVENT_PIN_OE && !FREQ_TEST_ACTIVE;
  endproperty
  property p_square_wave_enable; disable iff (1'b0) !RSTN && COLD_START |=> SQUARE_WAVE_ENABLE; endproperty
  property p_noabe; s_held(BACKUP_MODE && !abe_reg) |-> !SHARED_EVENT_PIN_OE; endproperty
  property p_bko0; s_held(BACKUP_MODE && abe_reg && !out_reg) |-> SHARED_EVENT_PIN_OE; endproperty
  property p_mo0; s_held(!BACKUP_MODE && !out_reg && !ft_reg) |-> SHARED_EVENT_PIN_OE; endproperty
  property p_ftoff; s_held(!ft_reg || BACKUP_MODE) |-> !FREQ_TEST_ACTIVE; endproperty
  property p_ftsel; s_held(!BACKUP_MODE && ft_reg && !out_reg) |-> FREQ_TEST_ACTIVE; endproperty
  a_drain: assert property (p_drain) else $error("pin data not low");
  a_rst: assert property (p_rst) else $error("pin active in reset");
  a_square_wave_enable: assert property (p_square_wave_enable) else $error("square enable not set");
  a_noabe: assert property (p_noabe) else $error("pin low, backup off");
  a_bko0: assert property (p_bko0) else $error("pin high, level 0");
  a_mo0: assert property (p_mo0) else $error("pin high, main level 0");
  a_ftoff: assert property (p_ftoff) else $error("test square wrongly on");
  a_ftsel: assert property (p_ftsel) else $error("test square missing");
endmodule
bind emp_event_pin_mux emp_event_pin_monitor emp_event_pin_monitor_inst (
  .CLOCK(CLOCK), .RSTN(RSTN), .COLD_START(COLD_START), .BACKUP_MODE(BACKUP_MODE),
  .REG_REQ(REG_REQ), .SHARED_EVENT_PIN_O(SHARED_EVENT_PIN_O),
  .SHARED_EVENT_PIN_OE(SHARED_EVENT_PIN_OE), .SQUARE_WAVE_ENABLE(SQUARE_WAVE_ENABLE),
  .FREQ_TEST_ACTIVE(FREQ_TEST_ACTIVE));
`default_nettype wire

//--- tb/emp_host_model.sv
// host side of the event pin: pull-up and a count of falling edges
// assumes pin_oe high while the selector pulls the wire
`timescale 1ns/1ps
`default_nettype none
module emp_host_model (
  input wire logic clock,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_wire,
  output int falls
);
  logic last_reg = 1'b1;
  assign pin_wire = pin_oe ? pin_o : 1'b1;
  initial falls = 0;
  // edges counted so a second flag is seen to cause no extra fall
  always @(posedge clock) begin
    last_reg <= pin_wire;
    if (last_reg && !pin_wire) falls <= falls + 1;
  end
endmodule
`default_nettype wire

//--- tb/event_pin_priority_mux_test.sv
// self-checking bench for the event pin selector with a host model
// assumes the test square half period is shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module event_pin_priority_mux_test;
  import emp_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cold = 1'b1;
  logic bkp = 1'b0;
  emp_reg_req_t req = '0;
  emp_src_t src = '0;
  logic [7:0] rdata;
  logic pin_o, pin_oe, square_wave_enable, ft_act, lvl;
  int falls;
  int mismatches = 0;
  int compares = 0;
  always #2.5 clock = ~clock;
  emp_event_pin_mux #(.FT_HALF(4)) emp_event_pin_mux_inst (
    .CLOCK(clock), .RSTN(rstn), .COLD_START(cold), .BACKUP_MODE(bkp), .REG_REQ(req),
    .REG_RDATA(rdata), .SRC_EVT(src), .SHARED_EVENT_PIN_O(pin_o),
    .SHARED_EVENT_PIN_OE(pin_oe), .SQUARE_WAVE_ENABLE(square_wave_enable), .FREQ_TEST_ACTIVE(ft_act));
  emp_host_model emp_host_model_inst (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_wire(lvl), .falls(falls));
  task automatic cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %b", $time, got);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    req = '0;
    cmp8(rdata, exp);
  endtask
  task automatic ev(input emp_src_t s);
    @(negedge clock);
    src = s;
    @(negedge clock);
    src = '0;
    repeat (2) @(negedge clock);
  endtask
  task automatic restart(input logic c);
    @(negedge clock);
    rstn = 1'b0;
    cold = c;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
  endtask
  task automatic t_cold();
    restart(1'b1);
    rd(ADDR_CAL, 8'h80);
    rd(ADDR_WDOG, 8'h00);
    rd(ADDR_A1MON, 8'h40);
    rd(ADDR_FLAGS, 8'h04);
    rd(8'h20, 8'h00);
    cmp1(square_wave_enable, 1'b1);
    cmp1(lvl, 1'b1);
  endtask
  task automatic t_ft();
    logic [7:0] v [2] = '{8'h40, 8'hC0};
    int f0;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CAL, v[i]);
      // first low half runs one cycle long, so count only steady periods
      repeat (4) @(negedge clock);
      f0 = falls;
      repeat (32) @(negedge clock);
      cmp1(ft_act, 1'b1);
      cmp1(falls - f0 == 4, 1'b1);
    end
    wr(ADDR_CAL, 8'h00);
    cmp1(lvl, 1'b0);
  endtask
  task automatic t_osc();
    wr(ADDR_CAL, 8'h80);
    wr(ADDR_WDOG, 8'h80);
    cmp1(lvl, 1'b0);
    rd(ADDR_FLAGS, 8'h04);
    cmp1(lvl, 1'b0);
    wr(ADDR_WDOG, 8'h00);
    cmp1(lvl, 1'b1);
    wr(ADDR_WDOG, 8'h80);
    cmp1(lvl, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    cmp1(lvl, 1'b1);
  endtask
  task automatic t_multi();
    int f0;
    wr(ADDR_A1MON, 8'hC0);
    ev(4'b0100);
    cmp1(lvl, 1'b0);
    f0 = falls;
    ev(4'b0001);
    cmp1(falls == f0, 1'b1);
    rd(ADDR_FLAGS, 8'h44);
    cmp1(lvl, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    cmp1(lvl, 1'b1);
    wr(ADDR_TCTL, 8'h20);
    ev(4'b1000);
    cmp1(lvl, 1'b0);
    rd(ADDR_FLAGS, 8'h08);
    wr(ADDR_WDOG, 8'h81);
    ev(4'b0010);
    cmp1(lvl, 1'b0);
    wr(ADDR_WDOG, 8'h80);
    cmp1(lvl, 1'b1);
  endtask
  task automatic t_backup();
    bkp = 1'b1;
    wr(ADDR_CAL, 8'h40);
    ev(4'b0001);
    cmp1(lvl, 1'b1);
    cmp1(ft_act, 1'b0);
    wr(ADDR_A1MON, 8'hE0);
    cmp1(lvl, 1'b0);
    wr(ADDR_CAL, 8'hC0);
    cmp1(lvl, 1'b0);
    wr(ADDR_FLAGS, 8'h00);
    ev(4'b1000);
    cmp1(lvl, 1'b1);
    ev(4'b0100);
    cmp1(lvl, 1'b0);
    rd(ADDR_FLAGS, 8'h40);
    wr(ADDR_A1MON, 8'h60);
    wr(ADDR_WDOG, 8'h00);
    ev(4'b0101);
    cmp1(lvl, 1'b1);
    wr(ADDR_FLAGS, 8'h00);
    bkp = 1'b0;
    repeat (3) @(negedge clock);
    cmp1(lvl, 1'b1);
    ev(4'b1000);
    cmp1(lvl, 1'b0);
    cmp1(ft_act, 1'b0);
    rd(ADDR_FLAGS, 8'h48);
  endtask
  task automatic t_warm();
    wr(ADDR_WDOG, 8'h85);
    restart(1'b0);
    rd(ADDR_CAL, 8'h80);
    rd(ADDR_WDOG, 8'h80);
    rd(ADDR_A1MON, 8'h60);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // about 250 cycles of traffic; the limit leaves ample margin
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
  initial begin
    t_cold();
    t_ft();
    t_osc();
    t_multi();
    t_backup();
    t_warm();
    give_verdict();
  end
endmodule
`default_nettype wire
